// ---- rtl/grfsc_consts.vh ----
// constants for the gyro rate, filter and sync configuration block
`ifndef GRFSC_CONSTS_VH
`define GRFSC_CONSTS_VH

// register addresses
`define GRFSC_ADDR_Z_OFFSET_LOW 8'h18
`define GRFSC_ADDR_RATE_DIVIDER 8'h19
`define GRFSC_ADDR_SYNC_FIFO_CFG 8'h1a
`define GRFSC_ADDR_RANGE_CFG 8'h1b

// reset values of the configuration registers
`define GRFSC_RST_BYTE 8'h00

// sync, fifo and filter configuration fields
`define GRFSC_FIFO_POLICY_BIT 6
`define GRFSC_SYNC_SEL_MSB 5
`define GRFSC_SYNC_SEL_LSB 3
`define GRFSC_LOWPASS_MSB 2
`define GRFSC_LOWPASS_LSB 0

// range and filter configuration fields
`define GRFSC_SELFTEST_X_BIT 7
`define GRFSC_SELFTEST_Y_BIT 6
`define GRFSC_SELFTEST_Z_BIT 5
`define GRFSC_RANGE_MSB 4
`define GRFSC_RANGE_LSB 3
`define GRFSC_BYPASS_MSB 1
`define GRFSC_BYPASS_LSB 0

// sync capture targets
`define GRFSC_SYNC_OFF 3'h0
`define GRFSC_SYNC_TEMP 3'h1
`define GRFSC_SYNC_ACCEL_X 3'h5
`define GRFSC_SYNC_ACCEL_Y 3'h6
`define GRFSC_SYNC_ACCEL_Z 3'h7

// lowpass settings that run at the fast internal rate
`define GRFSC_LOWPASS_FAST_LO 3'h0
`define GRFSC_LOWPASS_FAST_HI 3'h7

// gyro path rate codes
`define GRFSC_RATE_1K 2'h0
`define GRFSC_RATE_8K 2'h1
`define GRFSC_RATE_32K 2'h2

// full-scale ranges in degrees per second
`define GRFSC_DPS_250 11'h0fa
`define GRFSC_DPS_500 11'h1f4
`define GRFSC_DPS_1000 11'h3e8
`define GRFSC_DPS_2000 11'h7d0

// timing: clock and rates in hertz, periods in cycles
`define GRFSC_CLK_HZ 50000000
`define GRFSC_RATE_1K_HZ 1000
`define GRFSC_RATE_8K_HZ 8000
`define GRFSC_RATE_32K_HZ 32000
`define GRFSC_CYC_1K (`GRFSC_CLK_HZ / `GRFSC_RATE_1K_HZ)
`define GRFSC_CYC_8K (`GRFSC_CLK_HZ / `GRFSC_RATE_8K_HZ)
`define GRFSC_CYC_32K (`GRFSC_CLK_HZ / `GRFSC_RATE_32K_HZ)

`endif

// ---- rtl/grfsc_top.v ----
// gyro rate, filter, fifo policy and frame sync configuration block
//
// Behaviour
// - sample strobe runs at 1 kHz divided by one plus the divider byte.
// - divider applies only with bypass bits zero and lowpass setting 1 to 6.
// - policy bit one and fifo full: further sample writes are dropped.
// - policy bit zero and fifo full: writes continue, overwriting the oldest entry.
// - sync select 0 off, 1 temperature, 5/6/7 accel x/y/z low byte LSB.
// - sync input latched; toggles once, then holds until the sample strobe captures it.
// - gyro and temperature pass the lowpass stage only when both bypass bits are zero.
// - gyro path rate 32 kHz on bypass, else 8 kHz for 0 and 7, else 1 kHz.
// - range field selects 250, 500, 1000 or 2000 degrees per second.
// - two lowest range-register bits are bypass selects overriding the lowpass setting.
// - signed Z bias is added to the Z gyro sample before the output register.
// - Z bias is 16-bit two's complement, high byte from the preceding register.
`timescale 1ns/100ps
`default_nettype none
`include "grfsc_consts.vh"

module grfsc_top #(
    parameter CYC_1K = `GRFSC_CYC_1K,
    parameter CYC_8K = `GRFSC_CYC_8K
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // register port from the serial interface logic
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata_q,
    // high byte of the Z bias, held in the neighbouring register
    input wire [7:0] z_rate_bias_high,
    // external frame sync pin
    input wire frame_sync_input,
    // raw samples from the sensor front end
    input wire [15:0] gyro_z_raw,
    input wire [7:0] temp_low_raw,
    input wire [7:0] accel_x_low_raw,
    input wire [7:0] accel_y_low_raw,
    input wire [7:0] accel_z_low_raw,
    // sensor output registers
    output reg sample_strobe_q,
    output reg [15:0] gyro_z_out_q,
    output reg [7:0] temp_low_out_q,
    output reg [7:0] accel_x_low_byte_q,
    output reg [7:0] accel_y_low_byte_q,
    output reg [7:0] accel_z_low_byte_q,
    // fifo write control
    input wire fifo_full,
    output reg fifo_write_q,
    output reg fifo_drop_oldest_q,
    // filter and range control
    output reg lowpass_stage_en_q,
    output reg [2:0] lowpass_setting_q,
    output reg [1:0] gyro_rate_code_q,
    output reg gyro_rate_tick_q,
    output reg [1:0] rate_range_select_q,
    output reg [10:0] rate_range_dps_q,
    output reg x_rate_selftest_q,
    output reg y_rate_selftest_q,
    output reg z_rate_selftest_q
);

    localparam CYC_32K = `GRFSC_CYC_32K;

    reg [7:0] z_bias_low_q;
    reg [7:0] rate_divider_q;
    reg [7:0] sync_fifo_cfg_q;
    reg [7:0] range_cfg_q;
    reg [7:0] div_cnt_q;
    reg sync_meta_q;
    reg sync_s_q;
    reg sync_prev_q;
    reg sync_latched_q;
    reg sync_hold_q;
    reg [7:0] rd_d;
    wire [2:0] rate_tick;

    wire [1:0] bypass = range_cfg_q[`GRFSC_BYPASS_MSB:`GRFSC_BYPASS_LSB];
    wire [2:0] lowpass = sync_fifo_cfg_q[`GRFSC_LOWPASS_MSB:`GRFSC_LOWPASS_LSB];
    wire [2:0] sync_sel = sync_fifo_cfg_q[`GRFSC_SYNC_SEL_MSB:`GRFSC_SYNC_SEL_LSB];
    wire no_bypass = (bypass == 2'h0);
    wire lowpass_fast = (lowpass == `GRFSC_LOWPASS_FAST_LO) || (lowpass == `GRFSC_LOWPASS_FAST_HI);
    wire div_active = no_bypass && !lowpass_fast;
    wire [1:0] rate_code = !no_bypass ? `GRFSC_RATE_32K :
        (lowpass_fast ? `GRFSC_RATE_8K : `GRFSC_RATE_1K);
    wire path_tick = rate_tick[rate_code];
    wire div_done = (div_cnt_q >= rate_divider_q);
    // without the divider the strobe simply follows the internal rate
    wire strobe = div_active ? (rate_tick[0] && div_done) : path_tick;
    wire [15:0] z_bias = {z_rate_bias_high, z_bias_low_q};
    wire sync_edge = sync_s_q ^ sync_prev_q;

    // free running rate counters, one per internal rate
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1)
        begin : g_rate
            localparam integer PER = (gi == 0) ? CYC_1K : ((gi == 1) ? CYC_8K : CYC_32K);
            reg [15:0] cnt_q;
            assign rate_tick[gi] = (cnt_q == PER[15:0] - 16'h0001);
            always @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    cnt_q <= 16'h0000;
                else if (rate_tick[gi])
                    cnt_q <= 16'h0000;
                else
                    cnt_q <= cnt_q + 16'h0001;
            end
        end
    endgenerate

    // register writes; bit 7 of the sync register is kept as written by the host
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            z_bias_low_q <= `GRFSC_RST_BYTE;
            rate_divider_q <= `GRFSC_RST_BYTE;
            sync_fifo_cfg_q <= `GRFSC_RST_BYTE;
            range_cfg_q <= `GRFSC_RST_BYTE;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `GRFSC_ADDR_Z_OFFSET_LOW: z_bias_low_q <= reg_wdata;
                `GRFSC_ADDR_RATE_DIVIDER: rate_divider_q <= reg_wdata;
                `GRFSC_ADDR_SYNC_FIFO_CFG: sync_fifo_cfg_q <= reg_wdata;
                `GRFSC_ADDR_RANGE_CFG: range_cfg_q <= reg_wdata;
                default: z_bias_low_q <= z_bias_low_q;
            endcase
        end
    end

    always @*
    begin
        case (reg_addr)
            `GRFSC_ADDR_Z_OFFSET_LOW: rd_d = z_bias_low_q;
            `GRFSC_ADDR_RATE_DIVIDER: rd_d = rate_divider_q;
            `GRFSC_ADDR_SYNC_FIFO_CFG: rd_d = sync_fifo_cfg_q;
            `GRFSC_ADDR_RANGE_CFG: rd_d = range_cfg_q;
            default: rd_d = 8'h00;
        endcase
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata_q <= 8'h00;
        else if (reg_rd)
            reg_rdata_q <= rd_d;
    end

    // divider counts 1 kHz ticks; counting from zero gives one strobe per (1 + divider) ticks
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            div_cnt_q <= 8'h00;
        else if (!div_active)
            div_cnt_q <= 8'h00;
        else if (rate_tick[0])
            div_cnt_q <= div_done ? 8'h00 : div_cnt_q + 8'h01;
    end

    // sync pin: two flops, then an edge detector on the clean copy
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync_meta_q <= 1'b0;
            sync_s_q <= 1'b0;
            sync_prev_q <= 1'b0;
            sync_latched_q <= 1'b0;
            sync_hold_q <= 1'b0;
        end
        else
        begin
            sync_meta_q <= frame_sync_input;
            sync_s_q <= sync_meta_q;
            sync_prev_q <= sync_s_q;
            // a pulse shorter than a sample period still flips the latch once
            if (sync_edge && !sync_hold_q)
            begin
                sync_latched_q <= ~sync_latched_q;
                sync_hold_q <= 1'b1;
            end
            else if (strobe)
                sync_hold_q <= 1'b0;
        end
    end

    // sample outputs and fifo control
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sample_strobe_q <= 1'b0;
            gyro_z_out_q <= 16'h0000;
            temp_low_out_q <= 8'h00;
            accel_x_low_byte_q <= 8'h00;
            accel_y_low_byte_q <= 8'h00;
            accel_z_low_byte_q <= 8'h00;
            fifo_write_q <= 1'b0;
            fifo_drop_oldest_q <= 1'b0;
        end
        else
        begin
            sample_strobe_q <= strobe;
            // a full fifo under the keep policy refuses the write outright
            fifo_write_q <= strobe && !(fifo_full && sync_fifo_cfg_q[`GRFSC_FIFO_POLICY_BIT]);
            fifo_drop_oldest_q <= strobe && fifo_full && !sync_fifo_cfg_q[`GRFSC_FIFO_POLICY_BIT];
            if (strobe)
            begin
                gyro_z_out_q <= gyro_z_raw + z_bias;
                temp_low_out_q <= {temp_low_raw[7:1],
                    (sync_sel == `GRFSC_SYNC_TEMP) ? sync_latched_q : temp_low_raw[0]};
                accel_x_low_byte_q <= {accel_x_low_raw[7:1],
                    (sync_sel == `GRFSC_SYNC_ACCEL_X) ? sync_latched_q : accel_x_low_raw[0]};
                accel_y_low_byte_q <= {accel_y_low_raw[7:1],
                    (sync_sel == `GRFSC_SYNC_ACCEL_Y) ? sync_latched_q : accel_y_low_raw[0]};
                accel_z_low_byte_q <= {accel_z_low_raw[7:1],
                    (sync_sel == `GRFSC_SYNC_ACCEL_Z) ? sync_latched_q : accel_z_low_raw[0]};
            end
        end
    end

    // filter, rate and range controls
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lowpass_stage_en_q <= 1'b0;
            lowpass_setting_q <= 3'h0;
            gyro_rate_code_q <= `GRFSC_RATE_8K;
            gyro_rate_tick_q <= 1'b0;
            rate_range_select_q <= 2'h0;
            rate_range_dps_q <= `GRFSC_DPS_250;
            x_rate_selftest_q <= 1'b0;
            y_rate_selftest_q <= 1'b0;
            z_rate_selftest_q <= 1'b0;
        end
        else
        begin
            lowpass_stage_en_q <= no_bypass;
            lowpass_setting_q <= lowpass;
            gyro_rate_code_q <= rate_code;
            gyro_rate_tick_q <= path_tick;
            rate_range_select_q <= range_cfg_q[`GRFSC_RANGE_MSB:`GRFSC_RANGE_LSB];
            case (range_cfg_q[`GRFSC_RANGE_MSB:`GRFSC_RANGE_LSB])
                2'h0: rate_range_dps_q <= `GRFSC_DPS_250;
                2'h1: rate_range_dps_q <= `GRFSC_DPS_500;
                2'h2: rate_range_dps_q <= `GRFSC_DPS_1000;
                default: rate_range_dps_q <= `GRFSC_DPS_2000;
            endcase
            x_rate_selftest_q <= range_cfg_q[`GRFSC_SELFTEST_X_BIT];
            y_rate_selftest_q <= range_cfg_q[`GRFSC_SELFTEST_Y_BIT];
            z_rate_selftest_q <= range_cfg_q[`GRFSC_SELFTEST_Z_BIT];
        end
    end

endmodule // grfsc_top
`default_nettype wire

// ---- dv/grfsc_asserts.sv ----
// assertion checker for the gyro rate, filter and sync configuration block
`timescale 1ns/100ps
`default_nettype none
module grfsc_chk (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    // samples
    input wire logic [7:0] z_rate_bias_high,
    input wire logic [15:0] gyro_z_raw,
    input wire logic [7:0] temp_low_raw,
    input wire logic fifo_full,
    // outputs
    input wire logic sample_strobe_q,
    input wire logic [15:0] gyro_z_out_q,
    input wire logic [7:0] temp_low_out_q,
    input wire logic fifo_write_q,
    input wire logic fifo_drop_oldest_q,
    input wire logic lowpass_stage_en_q,
    input wire logic [1:0] gyro_rate_code_q,
    input wire logic [1:0] rate_range_select_q,
    input wire logic [10:0] rate_range_dps_q
);
    logic [7:0] zlo_q, cfg_q, rng_q;
    // shadows follow host writes so outputs can be tied to register contents
    always @(posedge clk or negedge rst_n)
        zlo_q <= !rst_n ? 8'h00 : (reg_wr && reg_addr == 8'h18) ? reg_wdata : zlo_q;
    always @(posedge clk or negedge rst_n)
        cfg_q <= !rst_n ? 8'h00 : (reg_wr && reg_addr == 8'h1a) ? reg_wdata : cfg_q;
    always @(posedge clk or negedge rst_n)
        rng_q <= !rst_n ? 8'h00 : (reg_wr && reg_addr == 8'h1b) ? reg_wdata : rng_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // two quiet cycles leave room for the output register stage
    sequence settled;
        rst_n && $stable(rng_q) && $stable(cfg_q) ##1 rst_n && $stable(rng_q) && $stable(cfg_q);
    endsequence
    bypass_gate_a:
        assert property (settled |-> lowpass_stage_en_q == (rng_q[1:0] == 2'h0))
        else $error("lowpass stage enable does not follow bypass bits");
    path_rate_a:
        assert property (settled |-> gyro_rate_code_q == (rng_q[1:0] != 2'h0 ? 2'h2 :
            (cfg_q[2:0] == 3'h0 || cfg_q[2:0] == 3'h7) ? 2'h1 : 2'h0)) else $error("gyro path rate wrong");
    range_map_a:
        assert property (settled |-> rate_range_select_q == rng_q[4:3] && rate_range_dps_q == (11'h0fa << rng_q[4:3]))
        else $error("full scale range wrong");
    // the design acts on the configuration seen at the strobe edge, one cycle before the outputs show it
    fifo_keep_a:
        assert property (sample_strobe_q && $past(cfg_q[6]) && $past(fifo_full) |-> !fifo_write_q)
        else $error("fifo write not dropped when full");
    fifo_over_a:
        assert property (sample_strobe_q && !$past(cfg_q[6]) |->
            fifo_write_q && fifo_drop_oldest_q == $past(fifo_full)) else $error("fifo overwrite control wrong");
    z_bias_a:
        assert property (sample_strobe_q && $stable(gyro_z_raw) && $stable(z_rate_bias_high) |->
            gyro_z_out_q == $past(gyro_z_raw) + {$past(z_rate_bias_high), $past(zlo_q)}) else $error("z sum wrong");
    temp_plain_a:
        assert property (sample_strobe_q && $past(cfg_q[5:3]) != 3'h1 && $stable(temp_low_raw) |->
            temp_low_out_q == $past(temp_low_raw)) else $error("temperature byte altered");
    strobe_gap_a:
        assert property (sample_strobe_q |=> !sample_strobe_q [*8])
        else $error("sample strobe too close");
endmodule // grfsc_chk
`default_nettype wire

// ---- dv/grfsc_host.sv ----
// host processor model on the register port
`timescale 1ns/100ps
`default_nettype none
module grfsc_host (
    // clock
    input wire logic clk,
    // register port
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata_q
);
    initial {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = (a == 8'h1a) ? {1'b0, d[6:0]} : d;
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~v;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata_q;
    endtask
endmodule // grfsc_host
`default_nettype wire

// ---- dv/grfsc_tb.sv ----
// self-checking bench for the gyro rate, filter and sync configuration block
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sync, full, eb;
    logic [7:0] zhi, tr, ax, ay, az, rv, zl, sel;
    logic [15:0] gz;
    integer seed = 32'hd252334c;
    int bad_count = 0;
    int n_tests = 0;
    int cyc = 0;
    int lat;
    wire [7:0] ra, wd, rdq, tout, xo, yo, zo;
    wire wr, rd, stb, fw, fd, lpe, rt, xs, ys, zs;
    wire [15:0] go;
    wire [10:0] dps;
    wire [2:0] lps;
    wire [1:0] rc;
    always #10 clk = ~clk;
    grfsc_host host (.clk(clk), .reg_addr(ra), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata_q(rdq));
    // 11 divides 44 and the fixed 1562-cycle 32 kHz period, so mode switches never crowd two strobes
    grfsc_top #(.CYC_1K(44), .CYC_8K(11)) dut (.clk(clk), .rst_n(rst_n), .reg_addr(ra), .reg_wdata(wd),
        .reg_wr(wr), .reg_rd(rd), .reg_rdata_q(rdq), .z_rate_bias_high(zhi), .frame_sync_input(sync),
        .gyro_z_raw(gz), .temp_low_raw(tr), .accel_x_low_raw(ax), .accel_y_low_raw(ay), .accel_z_low_raw(az),
        .sample_strobe_q(stb), .gyro_z_out_q(go), .temp_low_out_q(tout), .accel_x_low_byte_q(xo),
        .accel_y_low_byte_q(yo), .accel_z_low_byte_q(zo), .fifo_full(full), .fifo_write_q(fw),
        .fifo_drop_oldest_q(fd), .lowpass_stage_en_q(lpe), .lowpass_setting_q(lps), .gyro_rate_code_q(rc),
        .gyro_rate_tick_q(rt), .rate_range_select_q(), .rate_range_dps_q(dps), .x_rate_selftest_q(xs),
        .y_rate_selftest_q(ys), .z_rate_selftest_q(zs));
    function automatic logic [1:0] exp_rate(input logic [1:0] bp, input logic [2:0] lp);
        return bp != 2'h0 ? 2'h2 : (lp == 3'h0 || lp == 3'h7) ? 2'h1 : 2'h0;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic strobe(output int n);
        n = 0;
        do
        begin
            @(posedge clk);
            #1 n++;
        end while (stb !== 1'b1 && n < 4000);
    endtask
    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            bad_count++;
            report_and_stop();
        end
    end
    initial
    begin
        {sync, full, eb, zhi, gz, tr, ax, ay, az} = '0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        // reset contents, then random write and read back, unmapped place included
        for (int a = 8'h18; a < 8'h1d; a++)
        begin
            host.rd(a[7:0], rv);
            chk(rv, 16'h0);
            rv = 8'($random(seed));
            host.wr(a[7:0], rv);
            host.rd(a[7:0], zl);
            chk(zl, a == 8'h1c ? 8'h00 : a == 8'h1a ? rv & 8'h7f : rv);
        end
        for (int i = 0; i < 16; i++)
        begin
            sel = 8'($random(seed));
            host.wr(8'h1a, {5'h00, sel[2:0]});
            host.wr(8'h1b, {sel[7:5], i[1:0], 1'b0, i[3:2]});
            repeat (3) @(posedge clk);
            #1;
            chk(rc, exp_rate(i[3:2], sel[2:0]));
            chk(lpe, i[3:2] == 2'h0);
            chk(lps, sel[2:0]);
            chk(dps, 11'h0fa << i[1:0]);
            chk({xs, ys, zs}, sel[7:5]);
        end
        // divider honoured only for lowpass settings 1 to 6; the last pass runs on bypass at 32 kHz
        for (int k = 0; k < 5; k++)
        begin
            zl = 8'($random(seed));
            host.wr(8'h18, zl);
            host.wr(8'h19, k == 0 ? 8'h00 : 8'h02);
            host.wr(8'h1a, k < 2 ? 8'h03 : k == 2 ? 8'h07 : 8'h00);
            host.wr(8'h1b, k == 4 ? 8'h01 : 8'h00);
            @(posedge clk);
            gz <= 16'($random(seed));
            zhi <= 8'($random(seed));
            repeat (3) strobe(lat);
            chk(go, gz + {zhi, zl});
            strobe(lat);
            chk(lat[15:0], k == 0 ? 44 : k == 1 ? 132 : k == 4 ? 1562 : 11);
            chk(rt, 1'b1);
        end
        host.wr(8'h1b, 8'h00);
        for (int p = 0; p < 4; p++)
        begin
            host.wr(8'h1a, {1'b0, p[0], 6'h03});
            full <= p[1];
            repeat (2) strobe(lat);
            chk(fw, !(p[1] && p[0]));
            chk(fd, p[1] && !p[0]);
        end
        full <= 1'b0;
        host.wr(8'h19, 8'h00);
        // short pulse: rise flips the latch, the fall is lost until the strobe
        for (int s = 0; s < 6; s++)
        begin
            sel = s == 0 ? 8'h01 : s < 4 ? 8'(s + 4) : s == 4 ? 8'h02 : 8'h00;
            host.wr(8'h1a, {2'b00, sel[2:0], 3'h3});
            strobe(lat);
            @(posedge clk);
            {tr, ax, ay, az} <= $random(seed);
            sync <= 1'b1;
            repeat (2) @(posedge clk);
            sync <= 1'b0;
            eb = ~eb;
            strobe(lat);
            chk(tout, sel == 8'h01 ? {tr[7:1], eb} : tr);
            chk(xo, sel == 8'h05 ? {ax[7:1], eb} : ax);
            chk(yo, sel == 8'h06 ? {ay[7:1], eb} : ay);
            chk(zo, sel == 8'h07 ? {az[7:1], eb} : az);
        end
        report_and_stop();
    end
endmodule // tb
bind grfsc_top grfsc_chk u_chk (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .z_rate_bias_high(z_rate_bias_high), .gyro_z_raw(gyro_z_raw), .temp_low_raw(temp_low_raw),
    .fifo_full(fifo_full), .sample_strobe_q(sample_strobe_q), .gyro_z_out_q(gyro_z_out_q),
    .temp_low_out_q(temp_low_out_q), .fifo_write_q(fifo_write_q), .fifo_drop_oldest_q(fifo_drop_oldest_q),
    .lowpass_stage_en_q(lowpass_stage_en_q), .gyro_rate_code_q(gyro_rate_code_q),
    .rate_range_select_q(rate_range_select_q), .rate_range_dps_q(rate_range_dps_q));
`default_nettype wire
